// *** logic/timer_channel_regs.vh ***
// Register offsets, field positions, reset values and mode codes of the timer channel.
`ifndef TIMER_CHANNEL_REGS_VH
`define TIMER_CHANNEL_REGS_VH
// Byte addresses of the word-aligned registers.
`define OFF_TIMER_CTRL 8'h00
`define OFF_CHAN_CTRL_STATUS 8'h04
`define OFF_CHAN_VALUE_HIGH 8'h08
`define OFF_CHAN_VALUE_LOW 8'h0C
`define OFF_MODULO_VALUE 8'h10
`define OFF_COUNTER 8'h14
// Timer control fields.
`define CLOCK_SOURCE_SEL_LSB 0
`define CENTER_PWM_SELECT_BIT 2
`define PRESCALE_LSB 3
// Channel control/status fields.
`define EDGE_LEVEL_SEL_LSB 2
`define CHANNEL_MODE_SEL_LSB 4
`define CHAN_IRQ_ENABLE_BIT 6
`define CHAN_EVENT_FLAG_BIT 7
// Reset values.
`define TIMER_CTRL_RESET 8'h00
`define CHAN_CTRL_RESET 8'h00
`define CHAN_VALUE_RESET 16'h0000
`define MODULO_RESET 16'h0000
// Clock source codes.
`define CLK_NONE 2'b00
`define CLK_BUS 2'b01
`define CLK_FIXED 2'b10
`define CLK_EXT 2'b11
// Edge/level codes.
`define ELS_OFF 2'b00
`define ELS_RISE 2'b01
`define ELS_FALL 2'b10
`define ELS_BOTH 2'b11
// Decoded channel modes.
`define MODE_CAPTURE 2'd0
`define MODE_COMPARE 2'd1
`define MODE_EDGE_PWM 2'd2
`define MODE_CENTER_PWM 2'd3
// Counter limits.
`define COUNT_FREE_MAX 16'hFFFF
`define COUNT_ONE 16'h0001
`endif

// *** logic/timer_channel.v ***
// One 16-bit timer channel with shared counter, byte-coherent value register and APB slave.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "timer_channel_regs.vh"
// Contract
// RULE_01: edge/level 00 releases the pin.
// RULE_02: capture rising, falling or both edges.
// RULE_03: compare: none, toggle, clear, set pin.
// RULE_04: edge PWM high-true or low-true pulses.
// RULE_05: center PWM pulses on up-count compare.
// RULE_06: reset clears both value bytes.
// RULE_07: capture read latches pair until other read.
// RULE_08: status write resets byte coherency latches.
// RULE_09: value writes ignored in capture mode.
// RULE_10: read latch frozen during background debug.
// RULE_11: debug reads return live register contents.
// RULE_12: compare/PWM writes buffered, moved as pair.
// RULE_13: no clock: update at second byte.
// RULE_14: compare: update at next counter change.
// RULE_15: PWM: update at modulo minus one step.
// RULE_16: bytes accepted in either order.
// RULE_17: debug writes go straight to register.
// RULE_18: debug writes leave buffered sequence intact.
// RULE_19: one shared counter, prescaler, modulo register.
// RULE_20: center bit forces center PWM everywhere.
// RULE_21: center PWM counts up and down.
// RULE_22: event flag on capture or match, irq.
// RULE_23: flag cleared by read-then-write-zero sequence.
// RULE_24: clock source select codes, reset none.
// RULE_25: per-byte markers track coherent transfers.
module timer_channel (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire debug_active,
  input wire fixed_clk_tick,
  input wire ext_clk_pin,
  input wire chan_pin_in,
  output reg chan_pin_out,
  output wire chan_pin_oe,
  output wire chan_irq
);

  // Decodes the channel mode from the center bit and mode field.
  function [1:0] chan_mode;
    input center;
    input [1:0] ms;
    begin
      if (center) begin
        chan_mode = `MODE_CENTER_PWM; // [RULE_20]
      end else if (ms[1]) begin
        chan_mode = `MODE_EDGE_PWM;
      end else if (ms[0]) begin
        chan_mode = `MODE_COMPARE;
      end else begin
        chan_mode = `MODE_CAPTURE;
      end
    end
  endfunction

  reg [7:0] timer_ctrl;
  reg [7:0] chan_ctrl;
  reg chan_event_flag;
  reg flag_armed;
  reg [15:0] modulo_value;
  reg [15:0] counter;
  reg count_down;
  reg [7:0] presc_cnt;
  reg [15:0] chan_reg;
  reg [7:0] wbuf_hi;
  reg [7:0] wbuf_lo;
  reg hi_wmark;
  reg lo_wmark;
  reg wr_pending;
  reg [15:0] rbuf;
  reg [15:0] snap;
  reg hi_rmark;
  reg lo_rmark;
  reg pin_s1;
  reg pin_s2;
  reg pin_s3;
  reg ext_s1;
  reg ext_s2;
  reg ext_s3;
  reg [31:0] next_rdata;
  reg [15:0] next_counter;
  reg next_down;
  reg src_tick;

  wire [1:0] clock_source_sel = timer_ctrl[`CLOCK_SOURCE_SEL_LSB +: 2];
  wire center_pwm_select = timer_ctrl[`CENTER_PWM_SELECT_BIT];
  wire [2:0] prescale = timer_ctrl[`PRESCALE_LSB +: 3];
  wire [1:0] edge_level_sel = chan_ctrl[`EDGE_LEVEL_SEL_LSB +: 2];
  wire [1:0] channel_mode_sel = chan_ctrl[`CHANNEL_MODE_SEL_LSB +: 2];
  wire chan_irq_enable = chan_ctrl[`CHAN_IRQ_ENABLE_BIT];
  wire [1:0] mode = chan_mode(center_pwm_select, channel_mode_sel);
  wire is_capture = (mode == `MODE_CAPTURE);
  wire is_pwm = (mode == `MODE_EDGE_PWM) || (mode == `MODE_CENTER_PWM);

  // Bus strobes; every transfer completes in its first access cycle.
  wire setup_ph = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire sel_tctl = (paddr == `OFF_TIMER_CTRL);
  wire sel_csc = (paddr == `OFF_CHAN_CTRL_STATUS);
  wire sel_vh = (paddr == `OFF_CHAN_VALUE_HIGH);
  wire sel_vl = (paddr == `OFF_CHAN_VALUE_LOW);
  wire sel_mod = (paddr == `OFF_MODULO_VALUE);
  wire sel_cnt = (paddr == `OFF_COUNTER);
  wire mapped = sel_tctl | sel_csc | sel_vh | sel_vl | sel_mod | sel_cnt;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // A zero modulo means the counter runs free up to its full range.
  wire [15:0] term = (modulo_value == 16'h0000) ? `COUNT_FREE_MAX : modulo_value;
  wire [7:0] presc_limit = (8'h01 << prescale) - 8'h01;
  wire cnt_en = ce & src_tick & (presc_cnt == presc_limit) & ~debug_active; // [RULE_19]

  // Pin and external clock pass two flops before anything looks at them.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else if (ce) begin
      pin_s1 <= chan_pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      ext_s1 <= ext_clk_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  wire pin_rise = pin_s2 & ~pin_s3;
  wire pin_fall = ~pin_s2 & pin_s3;

  // Capture edge selection; edge/level 00 disables capture entirely.
  wire cap_event = is_capture & (((edge_level_sel == `ELS_RISE) & pin_rise) |
    ((edge_level_sel == `ELS_FALL) & pin_fall) | ((edge_level_sel == `ELS_BOTH) & (pin_rise | pin_fall))); // [RULE_02]

  // Counter clock source and next count value.
  always @* begin
    case (clock_source_sel) // [RULE_24]
      `CLK_BUS: src_tick = 1'b1;
      `CLK_FIXED: src_tick = fixed_clk_tick;
      `CLK_EXT: src_tick = ext_s2 & ~ext_s3;
      default: src_tick = 1'b0;
    endcase
    next_down = count_down;
    if (!center_pwm_select) begin
      next_down = 1'b0;
      next_counter = (counter >= term) ? 16'h0000 : counter + `COUNT_ONE; // [RULE_21]
    end else if (!count_down) begin
      if (counter >= term) begin
        next_down = (term != 16'h0000);
        next_counter = (term == 16'h0000) ? 16'h0000 : counter - `COUNT_ONE; // [RULE_21]
      end else begin
        next_counter = counter + `COUNT_ONE;
      end
    end else begin
      if (counter == 16'h0000) begin
        next_down = 1'b0;
        next_counter = `COUNT_ONE;
      end else begin
        next_counter = counter - `COUNT_ONE;
      end
    end
  end

  // Shared counter with prescaler; frozen while debug is active.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= 16'h0000;
      count_down <= 1'b0;
      presc_cnt <= 8'h00;
    end else if (ce) begin
      if (wr & sel_cnt) begin
        counter <= 16'h0000;
        count_down <= 1'b0;
        presc_cnt <= 8'h00;
      end else if (src_tick & ~debug_active) begin
        if (presc_cnt == presc_limit) begin
          presc_cnt <= 8'h00;
          counter <= next_counter;
          count_down <= next_down;
        end else begin
          presc_cnt <= presc_cnt + 8'h01;
        end
      end
    end
  end

  // Compare match when the counter steps onto the channel value.
  wire match = cnt_en & ~is_capture & (next_counter == chan_reg);
  // PWM at 0% or 100% duty never raises the flag.
  wire duty_edge = (chan_reg != 16'h0000) & (chan_reg <= term);
  wire up_match = (mode != `MODE_CENTER_PWM) | ~next_down;
  wire cmp_event = match & (~is_pwm | (duty_edge & up_match)); // [RULE_22]
  wire chan_event = cap_event | cmp_event;

  // Buffered pair loads at the point the current mode allows.
  wire pwm_load = cnt_en & (counter == term - `COUNT_ONE) & (next_counter == term); // [RULE_15]
  wire load_ok = (clock_source_sel == `CLK_NONE) | (is_pwm ? pwm_load : cnt_en); // [RULE_14]

  // Value byte writes outside debug and outside capture go to the buffer.
  wire vwr = wr & (sel_vh | sel_vl) & ~is_capture; // [RULE_09]
  wire buf_wr = vwr & ~debug_active;
  wire dbg_wr = vwr & debug_active;
  wire second = (sel_vh & lo_wmark) | (sel_vl & hi_wmark); // [RULE_16]
  wire [15:0] pair = sel_vh ? {pwdata[7:0], wbuf_lo} : {wbuf_hi, pwdata[7:0]};
  wire csc_wr = wr & sel_csc;

  // Write coherency buffer; its markers ignore value writes during debug.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wbuf_hi <= 8'h00;
      wbuf_lo <= 8'h00;
      hi_wmark <= 1'b0;
      lo_wmark <= 1'b0;
      wr_pending <= 1'b0;
    end else if (ce) begin
      if (wr_pending & load_ok & ~debug_active) begin
        wr_pending <= 1'b0;
      end
      if (csc_wr) begin
        hi_wmark <= 1'b0; // [RULE_08]
        lo_wmark <= 1'b0; // [RULE_25]
      end else if (buf_wr) begin
        if (sel_vh) begin
          wbuf_hi <= pwdata[7:0]; // [RULE_12]
        end else begin
          wbuf_lo <= pwdata[7:0];
        end
        if (second) begin
          hi_wmark <= 1'b0; // [RULE_25]
          lo_wmark <= 1'b0;
          wr_pending <= (clock_source_sel != `CLK_NONE);
        end else begin
          hi_wmark <= hi_wmark | sel_vh;
          lo_wmark <= lo_wmark | sel_vl;
        end
      end
    end
  end

  // Channel register: capture, coherent load, or direct debug write.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_reg <= `CHAN_VALUE_RESET; // [RULE_06]
    end else if (ce) begin
      if (cap_event) begin
        chan_reg <= counter;
      end else if (dbg_wr) begin
        if (sel_vh) begin
          chan_reg[15:8] <= pwdata[7:0]; // [RULE_17]
        end else begin
          chan_reg[7:0] <= pwdata[7:0]; // [RULE_18]
        end
      end else if (buf_wr & second & (clock_source_sel == `CLK_NONE)) begin
        chan_reg <= pair; // [RULE_13]
      end else if (wr_pending & load_ok & ~debug_active) begin
        chan_reg <= {wbuf_hi, wbuf_lo}; // [RULE_14]
      end
    end
  end

  // Read coherency latch for capture mode; frozen during debug.
  wire vrd = rd & (sel_vh | sel_vl) & is_capture & ~debug_active; // [RULE_10]
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rbuf <= 16'h0000;
      snap <= 16'h0000;
      hi_rmark <= 1'b0;
      lo_rmark <= 1'b0;
    end else if (ce) begin
      if (setup_ph) begin
        snap <= chan_reg;
      end
      if (csc_wr) begin
        hi_rmark <= 1'b0; // [RULE_08]
        lo_rmark <= 1'b0;
      end else if (vrd) begin
        if ((sel_vh & lo_rmark) | (sel_vl & hi_rmark)) begin
          hi_rmark <= 1'b0; // [RULE_25]
          lo_rmark <= 1'b0;
        end else begin
          rbuf <= snap; // [RULE_07]
          hi_rmark <= sel_vh;
          lo_rmark <= sel_vl;
        end
      end
    end
  end

  // Software registers and the event flag with its clear sequence.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ctrl <= `TIMER_CTRL_RESET; // [RULE_24]
      chan_ctrl <= `CHAN_CTRL_RESET;
      modulo_value <= `MODULO_RESET;
      chan_event_flag <= 1'b0;
      flag_armed <= 1'b0;
    end else if (ce) begin
      if (wr & sel_tctl) begin
        timer_ctrl <= pwdata[7:0];
      end
      if (wr & sel_mod) begin
        modulo_value <= pwdata[15:0];
      end
      if (csc_wr) begin
        chan_ctrl <= {1'b0, pwdata[6:0]};
      end
      // A new event wins over a clear in the same cycle and restarts the sequence.
      if (chan_event) begin
        chan_event_flag <= 1'b1; // [RULE_22]
        flag_armed <= 1'b0; // [RULE_23]
      end else if (csc_wr & flag_armed & ~pwdata[`CHAN_EVENT_FLAG_BIT]) begin
        chan_event_flag <= 1'b0; // [RULE_23]
        flag_armed <= 1'b0;
      end else if (rd & sel_csc & chan_event_flag) begin
        flag_armed <= 1'b1;
      end
    end
  end

  // Read data is formed in the setup cycle and held through the access cycle.
  always @* begin
    next_rdata = 32'h0000_0000;
    if (sel_tctl) begin
      next_rdata[7:0] = timer_ctrl;
    end else if (sel_csc) begin
      next_rdata[7:0] = {chan_event_flag, chan_ctrl[6:0]};
    end else if (sel_vh) begin
      next_rdata[7:0] = (is_capture & ~debug_active & lo_rmark) ? rbuf[15:8] : chan_reg[15:8]; // [RULE_11]
    end else if (sel_vl) begin
      next_rdata[7:0] = (is_capture & ~debug_active & hi_rmark) ? rbuf[7:0] : chan_reg[7:0]; // [RULE_11]
    end else if (sel_mod) begin
      next_rdata[15:0] = modulo_value;
    end else if (sel_cnt) begin
      next_rdata[15:0] = counter;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce & setup_ph & ~pwrite) begin
      prdata <= next_rdata;
    end
  end

  // Pin drive; PWM level follows the counter, compare acts only on a match.
  wire low_true = edge_level_sel[0];
  wire pwm_level = (counter < chan_reg) ^ low_true; // [RULE_04]
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_pin_out <= 1'b0;
    end else if (ce) begin
      if (is_pwm) begin
        chan_pin_out <= pwm_level; // [RULE_05]
      end else if ((mode == `MODE_COMPARE) & match) begin
        case (edge_level_sel)
          `ELS_RISE: chan_pin_out <= ~chan_pin_out; // [RULE_03]
          `ELS_FALL: chan_pin_out <= 1'b0;
          `ELS_BOTH: chan_pin_out <= 1'b1;
          default: chan_pin_out <= chan_pin_out;
        endcase
      end
    end
  end

  // The pin is only driven outside capture and never with edge/level 00.
  assign chan_pin_oe = (edge_level_sel != `ELS_OFF) & ~is_capture; // [RULE_01]
  assign chan_irq = chan_event_flag & chan_irq_enable; // [RULE_22]

endmodule // timer_channel

// *** dv/timer_channel_chk.sv ***
// Port-level assertions for the timer channel.
`timescale 1ns/1ps
module timer_channel_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire chan_pin_oe,
  input wire chan_irq
);
  reg [7:0] cs;
  reg ctr;
  wire wr = psel && penable && pwrite;
  // Shadow copies of the mode fields, taken from completed writes only.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs <= 8'h00;
      ctr <= 1'b0;
    end else if (wr && paddr == 8'h04) begin
      cs <= pwdata[7:0];
    end else if (wr && paddr == 8'h00) begin
      ctr <= pwdata[2];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence access_phase;
    psel && penable;
  endsequence
  sequence unmapped_access;
    access_phase ##0 paddr > 8'h14;
  endsequence
  a_pin_release: assert property (cs[3:2] == 2'b00 |-> !chan_pin_oe)
    else $error("pin driven while released");
  a_capture_input: assert property (!ctr && cs[5:4] == 2'b00 |-> !chan_pin_oe)
    else $error("pin driven in capture mode");
  a_compare_drive: assert property (!ctr && cs[5:4] == 2'b01 && cs[3:2] != 2'b00 |-> chan_pin_oe)
    else $error("compare pin not driven");
  a_edge_pwm_drive: assert property (!ctr && cs[5] && cs[3:2] != 2'b00 |-> chan_pin_oe)
    else $error("edge pwm pin not driven");
  a_center_drive: assert property (ctr && cs[3:2] != 2'b00 |-> chan_pin_oe)
    else $error("center pwm pin not driven");
  a_irq_masked: assert property (!cs[6] |-> !chan_irq)
    else $error("interrupt while disabled");
  // Checked from the second edge of reset on, once the asynchronous clear has surely reached every flop.
  a_reset_quiet: assert property (disable iff (1'b0) !presetn && $past(!presetn) |-> prdata == 32'h0000_0000 && !chan_irq)
    else $error("outputs active in reset");
  a_unmapped_err: assert property (unmapped_access |-> pslverr)
    else $error("no error on unmapped access");
  a_ready_access: assert property (access_phase |-> pready && $stable(paddr))
    else $error("access not answered");
endmodule // timer_channel_chk
bind timer_channel timer_channel_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .chan_pin_oe, .chan_irq);

// *** dv/pin_partner.sv ***
// Model of the outside world at the channel pin and the external clock pin.
`timescale 1ns/1ps
module pin_partner (
  input wire pclk,
  input wire level,
  input wire ext_run,
  input wire chan_pin_out,
  input wire chan_pin_oe,
  output wire chan_pin_in,
  output reg ext_clk_pin
);
  reg [1:0] div;
  initial begin
    div = 2'h0;
    ext_clk_pin = 1'b0;
  end
  // The pad follows the channel while it drives, else the outside level.
  assign chan_pin_in = chan_pin_oe ? chan_pin_out : level;
  // The source runs at an eighth of the bus rate, well under the sync limit, and stands still when idle.
  always @(posedge pclk) begin
    div <= div + 2'h1;
    if (ext_run && div == 2'h3) begin
      ext_clk_pin <= !ext_clk_pin;
    end
  end
endmodule // pin_partner

// *** dv/timer_channel_mode_and_value_coherency_bench.sv ***
// Self-checking bench for the timer channel.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module timer_channel_mode_and_value_coherency_bench;
  reg pclk, presetn, psel, penable, pwrite, debug_active, fixed_clk_tick, level, ext_run, perr, prev;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  reg [15:0] rv;
  wire [31:0] prdata;
  wire pready, pslverr, chan_pin_in, chan_pin_out, chan_pin_oe, chan_irq, ext_clk_pin;
  integer fail_count = 0;
  integer n_compared = 0;
  integer i, n;
  timer_channel i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_active(debug_active), .fixed_clk_tick(fixed_clk_tick), .ext_clk_pin(ext_clk_pin),
    .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .chan_irq(chan_irq));
  pin_partner i_pin (.pclk(pclk), .level(level), .ext_run(ext_run), .chan_pin_out(chan_pin_out),
    .chan_pin_oe(chan_pin_oe), .chan_pin_in(chan_pin_in), .ext_clk_pin(ext_clk_pin));
  // A 40 MHz bus clock.
  always #12.5 pclk = ~pclk;
  task stop_test;
    begin
      if (fail_count == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // One APB transfer; an idle cycle follows so calls never collide.
  task apb(input [7:0] a, input w, input [15:0] d);
    integer k;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge pclk);
        k = k + 1;
      end while (!pready && k < 16);
      if (!pready) begin
        fail_count++;
        stop_test;
      end
      rv = prdata[15:0];
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input [7:0] a);
    apb(a, 1'b0, 16'h0000);
  endtask
  // Each tick is one counter step at prescale zero (divide by one).
  task tick(input integer t);
    repeat (t) begin
      fixed_clk_tick <= 1'b1;
      @(posedge pclk);
      fixed_clk_tick <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // The pin path has a two to three cycle synchroniser.
  task pin(input v);
    begin
      level <= v;
      repeat (5) @(posedge pclk);
    end
  endtask
  task t_reset;
    begin
      rd(8'h08); `CHK("value high", 16'h0000, rv)
      rd(8'h0C); `CHK("value low", 16'h0000, rv)
      rd(8'h00); `CHK("timer ctrl", 16'h0000, rv)
      rd(8'h18); `CHK("unmapped err", 1'b1, perr)
    end
  endtask
  task t_writes;
    begin
      wr(8'h04, 16'h0010); wr(8'h08, 16'h0012);
      rd(8'h08); `CHK("half written", 16'h0000, rv)
      wr(8'h0C, 16'h0034);
      rd(8'h08); `CHK("pair high", 16'h0012, rv)
      rd(8'h0C); `CHK("pair low", 16'h0034, rv)
      wr(8'h0C, 16'h0078); wr(8'h08, 16'h0056);
      rd(8'h08); `CHK("swap high", 16'h0056, rv)
      wr(8'h04, 16'h0004); wr(8'h08, 16'h00FF); wr(8'h0C, 16'h00FF);
      rd(8'h08); `CHK("capture high", 16'h0056, rv)
      rd(8'h0C); `CHK("capture low", 16'h0078, rv)
    end
  endtask
  task t_debug;
    begin
      wr(8'h04, 16'h0010); wr(8'h08, 16'h00AA);
      debug_active <= 1'b1;
      wr(8'h0C, 16'h0011);
      rd(8'h0C); `CHK("debug low", 16'h0011, rv)
      rd(8'h08); `CHK("debug high", 16'h0056, rv)
      debug_active <= 1'b0;
      wr(8'h0C, 16'h00BB);
      rd(8'h08); `CHK("resumed high", 16'h00AA, rv)
      rd(8'h0C); `CHK("resumed low", 16'h00BB, rv)
    end
  endtask
  task t_capture;
    begin
      wr(8'h00, 16'h0002); wr(8'h04, 16'h0004); wr(8'h14, 16'h0000);
      tick(255); pin(1'b1);
      rd(8'h04); `CHK("capture flag", 1'b1, rv[7])
      wr(8'h04, 16'h0008);
      rd(8'h0C); `CHK("rise capture", 16'h00FF, rv)
      tick(1); pin(1'b0);
      debug_active <= 1'b1;
      rd(8'h08); `CHK("live in debug", 16'h0001, rv)
      debug_active <= 1'b0;
      rd(8'h08); `CHK("latched high", 16'h0000, rv)
      rd(8'h08); `CHK("fall capture", 16'h0001, rv)
      tick(1); pin(1'b1); pin(1'b0);
      wr(8'h04, 16'h000C);
      rd(8'h0C); `CHK("latch reset", 16'h0001, rv)
    end
  endtask
  task t_compare;
    reg [1:0] els [0:3];
    reg exp [0:3];
    begin
      els = '{2'h3, 2'h1, 2'h3, 2'h2};
      exp = '{1'b1, 1'b0, 1'b1, 1'b0};
      // Arm and clear the flag left by the capture test, so the first match is seen on its own.
      rd(8'h04);
      wr(8'h00, 16'h0000); wr(8'h04, 16'h0010); wr(8'h08, 16'h0000); wr(8'h0C, 16'h0002);
      wr(8'h00, 16'h0002);
      for (i = 0; i < 4; i++) begin
        wr(8'h04, {8'h00, 2'h1, 2'h1, els[i], 2'h0});
        wr(8'h14, 16'h0000); tick(2); @(posedge pclk);
        `CHK("compare pin", exp[i], chan_pin_out)
        `CHK("compare irq", 1'b1, chan_irq)
        rd(8'h04);
      end
      wr(8'h04, 16'h00D0);
      `CHK("write one", 1'b1, chan_irq)
      rd(8'h04); wr(8'h04, 16'h0050);
      `CHK("flag cleared", 1'b0, chan_irq)
      wr(8'h08, 16'h0012); wr(8'h0C, 16'h0034);
      rd(8'h0C); `CHK("compare held", 16'h0002, rv)
      tick(1);
      rd(8'h0C); `CHK("compare loaded", 16'h0034, rv)
    end
  endtask
  task t_pwm;
    begin
      wr(8'h00, 16'h0000); wr(8'h10, 16'h0004); wr(8'h04, 16'h0028);
      wr(8'h08, 16'h0000); wr(8'h0C, 16'h0002);
      wr(8'h00, 16'h0002); wr(8'h14, 16'h0000); @(posedge pclk);
      `CHK("pwm high", 1'b1, chan_pin_out)
      tick(2); @(posedge pclk);
      `CHK("pwm cleared", 1'b0, chan_pin_out)
      wr(8'h08, 16'h0000); wr(8'h0C, 16'h0003); @(posedge pclk);
      `CHK("held until end", 1'b0, chan_pin_out)
      tick(5); @(posedge pclk);
      `CHK("loaded at end", 1'b1, chan_pin_out)
      wr(8'h04, 16'h0024); @(posedge pclk);
      `CHK("low true", 1'b0, chan_pin_out)
      wr(8'h00, 16'h0006); wr(8'h14, 16'h0000); tick(4);
      rd(8'h14); `CHK("count up", 16'h0004, rv)
      tick(1);
      rd(8'h14); `CHK("count down", 16'h0003, rv)
      `CHK("center pin", 1'b1, chan_pin_out)
    end
  endtask
  task t_clocks;
    begin
      wr(8'h00, 16'h0000); wr(8'h10, 16'h0000); wr(8'h14, 16'h0000); wr(8'h00, 16'h0003);
      ext_run <= 1'b1;
      n = 0;
      prev = ext_clk_pin;
      // Keep watching after the source stops, so an edge launched together with the stop is counted too.
      for (i = 0; i < 72; i++) begin
        @(posedge pclk);
        if (i == 63) ext_run <= 1'b0;
        if (ext_clk_pin && !prev) n++;
        prev = ext_clk_pin;
      end
      wr(8'h00, 16'h0000);
      rd(8'h14); `CHK("external count", n[15:0], rv)
      wr(8'h00, 16'h0001); rd(8'h14);
      `CHK("bus clock runs", 1'b1, rv != 16'h0000)
      wr(8'h00, 16'h0000); wr(8'h14, 16'h0000); wr(8'h00, 16'h000A); tick(6);
      rd(8'h14); `CHK("prescaled count", 16'h0003, rv)
    end
  endtask
  // Reset, then one scenario after another.
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; debug_active = 1'b0; fixed_clk_tick = 1'b0; level = 1'b0; ext_run = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset; t_writes; t_debug; t_capture; t_compare; t_pwm; t_clocks;
    stop_test;
  end
  // A hang ends the run as a failure.
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    stop_test;
  end
endmodule // timer_channel_mode_and_value_coherency_bench
